// file: logic/ivp_top.sv
// Serial control slave with power mode, switch and load-detect logic
//
// Functional notes
// - All four enables zero gives shutdown, normal switch range, no detection.
// - Signal path and pump enables both set run everything, extended range.
// - Pump enable alone without auto path keeps pump on, video off.
// - Both auto bits drive path and pump from load; extended only with pump.
// - Auto path with pump enable keeps pump on, video follows load.
// - Config bits 7 and 6 close switch two and switch one.
// - Config bit 4 turns the sync-tip clamp on.
// - Config bit 3 turns the video filter on, else bypass.
// - Manual enables override auto bits; path waits for settled pump.
// - Load bit read-only; reading it with flag enabled releases the flag.
// - With flag enabled each load change pulls the flag pin low.
// - Auto path turns path on once load seen and pump settled.
// - Auto pump turns pump on whenever load is detected.
// - Master makes the clock up to 400kHz and starts all transfers.
// - STOP is honoured anywhere except in the high pulse of a START.
// - Strap tie selects address bits 2:1; write base 0x98.
// - Each good byte received is acknowledged for the ninth pulse.
// - Pointer advances after every written data byte.
// - Reads follow pointer write and repeated START; pointer advances.
// - Read bits change after clock falls, valid at the rising edge.
// - Reads beyond the last register return all ones.
// - Pointer survives STOP; next read starts where the last ended.
// - Load status changes pass a 128ms debounce first.
`timescale 1ns/10ps
`include "ivp_regs.svh"

module ivp_top import ivp_pkg::*; #(
	parameter int unsigned DEB_CYC = `IVP_DEBOUNCE_MS * `IVP_CLK_KHZ
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic slave_address_strap,
	input wire logic cp_settled_i,
	input wire logic sense_clk,
	input wire logic load_sense_i,
	output logic sda_o,
	output logic sda_oe,
	output logic load_change_flag_n_o,
	output logic load_change_flag_n_oe,
	output logic charge_pump_run_o,
	output logic signal_path_run_o,
	output logic switch_ext_range_o,
	output logic switch_one_close_o,
	output logic switch_two_close_o,
	output logic sync_tip_clamp_on_o,
	output logic video_filter_on_o,
	output logic load_sense_on_o
);

	ivp_pins_t pin_m_q, pin_s_q, pin_p_q;
	ivp_state_t state_q;
	ivp_cfg_t cfg_q;
	ivp_ld_t ld_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q, ptr_q, rd_byte;
	logic rw_q, ack_n_q, oe_q, start_hi_q;
	logic strap_a_q, strap_b_q;
	logic rise, fall, start, stop, byte_end, ack_end, wr_en, rd_load, rd_clr;
	logic [23:0] deb_cnt_q;
	logic load_st_q, load_chg, detect_q, flag_q;
	logic cp_run_q, sp_run_q, ext_q;
	logic srst_m_q, srst_s_q, en_m_q, en_s_q, raw_m_q, raw_s_q;
	logic sense_on_q, hit_q;

	// Address bits 2:1 from the strap: value at START and just before first rise
	function automatic logic addr_match(input logic [7:0] b, input logic sa, input logic sb);
		addr_match = (b[7:3] == `IVP_ADDR_HI) && (b[2:1] == {sa ^ sb, sb});
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] p, input ivp_cfg_t c,
		input ivp_ld_t l);
		if (p == `IVP_CFG_ADDR) begin
			reg_read = c & `IVP_CFG_WMASK;
		end else if (p == `IVP_LD_ADDR) begin
			reg_read = l;
		end else begin
			reg_read = `IVP_DUMMY_DATA;
		end
	endfunction

	// Pins from outside, two flops deep; third stage for edges and the strap's pre-rise sample
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_m_q <= 5'h1C;
			pin_s_q <= 5'h1C;
			pin_p_q <= 5'h1C;
		end else begin
			pin_m_q <= '{scl: scl_i, sda: sda_i, strap: slave_address_strap,
				settled: cp_settled_i, load_hit: hit_q};
			pin_s_q <= pin_m_q;
			pin_p_q <= pin_s_q;
		end
	end

	assign rise = pin_s_q.scl && !pin_p_q.scl;
	assign fall = !pin_s_q.scl && pin_p_q.scl;
	assign start = pin_s_q.scl && pin_p_q.scl && pin_p_q.sda && !pin_s_q.sda;
	assign stop = pin_s_q.scl && pin_p_q.scl && !pin_p_q.sda && pin_s_q.sda
		&& !start_hi_q;
	assign byte_end = fall && (cnt_q == `IVP_BYTE_BITS);
	assign ack_end = fall && (cnt_q == `IVP_ACK_BITS);
	assign wr_en = byte_end && (state_q == ST_WDATA);
	assign rd_load = ack_end && (((state_q == ST_ADDR) && rw_q)
		|| ((state_q == ST_RDATA) && !ack_n_q));
	assign rd_byte = reg_read(ptr_q, cfg_q, ld_q);
	assign rd_clr = rd_load && (ptr_q == `IVP_LD_ADDR) && ld_q.load_change_flag_on;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			start_hi_q <= 1'b0;
		end else if (start) begin
			start_hi_q <= 1'b1;
		end else if (!pin_s_q.scl) begin
			start_hi_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			strap_a_q <= 1'b0;
			strap_b_q <= 1'b0;
		end else if (start) begin
			strap_a_q <= pin_s_q.strap;
		end else if (rise && (state_q == ST_ADDR) && (cnt_q == 4'h0)) begin
			strap_b_q <= pin_p_q.strap;
		end
	end

	// Frame engine; moved by START, STOP and the master's clock edges
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= `IVP_CFG_ADDR;
			rw_q <= 1'b0;
			ack_n_q <= 1'b1;
			oe_q <= 1'b0;
		end else if (start) begin
			state_q <= ST_ADDR;
			cnt_q <= 4'h0;
			oe_q <= 1'b0;
		end else if (stop) begin
			state_q <= ST_IDLE;
			oe_q <= 1'b0;
		end else if (state_q != ST_IDLE) begin
			if (rise) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q < `IVP_BYTE_BITS && state_q != ST_RDATA) begin
					shift_q <= {shift_q[6:0], pin_s_q.sda};
				end
				if (cnt_q == `IVP_BYTE_BITS) begin
					ack_n_q <= pin_s_q.sda;
				end
			end
			if (byte_end) begin
				case (state_q)
					ST_ADDR: begin
						if (addr_match(shift_q, strap_a_q, strap_b_q)) begin
							oe_q <= 1'b1;
							rw_q <= shift_q[0];
						end else begin
							state_q <= ST_IDLE;
						end
					end
					ST_PTR: begin
						oe_q <= 1'b1;
						ptr_q <= shift_q;
					end
					ST_WDATA: begin
						oe_q <= 1'b1;
						ptr_q <= ptr_q + 8'h01;
					end
					ST_RDATA: begin
						oe_q <= 1'b0;
					end
					default: begin
						oe_q <= 1'b0;
					end
				endcase
			end else if (ack_end) begin
				cnt_q <= 4'h0;
				oe_q <= 1'b0;
				case (state_q)
					ST_ADDR: begin
						state_q <= rw_q ? ST_RDATA : ST_PTR;
					end
					ST_PTR: begin
						state_q <= ST_WDATA;
					end
					ST_WDATA: begin
						state_q <= ST_WDATA;
					end
					ST_RDATA: begin
						if (ack_n_q) begin
							state_q <= ST_IDLE;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
				if (rd_load) begin
					shift_q <= rd_byte;
					oe_q <= !rd_byte[7];
					ptr_q <= ptr_q + 8'h01;
				end
			end else if (fall && state_q == ST_RDATA && cnt_q != 4'h0) begin
				shift_q <= {shift_q[6:0], 1'b0};
				oe_q <= !shift_q[6];
			end
		end
	end

	// Register bank; reserved bits masked on write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_q <= `IVP_CFG_RST;
			ld_q <= `IVP_LD_RST;
		end else begin
			if (wr_en && ptr_q == `IVP_CFG_ADDR) begin
				cfg_q <= shift_q & `IVP_CFG_WMASK;
			end
			if (wr_en && ptr_q == `IVP_LD_ADDR) begin
				ld_q.load_change_flag_on <= shift_q[3];
				ld_q.auto_signal_path <= shift_q[1];
				ld_q.auto_charge_pump <= shift_q[0];
			end
			ld_q.load <= load_st_q;
		end
	end

	// Debounce in the main domain; status forced clear while sensing is off
	always_ff @(posedge clk) begin
		if (!nrst) begin
			detect_q <= 1'b0;
			deb_cnt_q <= 24'h000000;
			load_st_q <= 1'b0;
		end else begin
			detect_q <= ld_q.auto_signal_path || ld_q.auto_charge_pump;
			if (!detect_q) begin
				deb_cnt_q <= 24'h000000;
				load_st_q <= 1'b0;
			end else if (pin_s_q.load_hit == load_st_q) begin
				deb_cnt_q <= 24'h000000;
			end else if (deb_cnt_q == 24'(DEB_CYC - 1)) begin
				deb_cnt_q <= 24'h000000;
				load_st_q <= pin_s_q.load_hit;
			end else begin
				deb_cnt_q <= deb_cnt_q + 24'h000001;
			end
		end
	end

	assign load_chg = detect_q && (deb_cnt_q == 24'(DEB_CYC - 1))
		&& (pin_s_q.load_hit != load_st_q);

	// A new change in the clearing read's cycle keeps the flag
	always_ff @(posedge clk) begin
		if (!nrst) begin
			flag_q <= 1'b0;
		end else if (load_chg && ld_q.load_change_flag_on) begin
			flag_q <= 1'b1;
		end else if (rd_clr || !ld_q.load_change_flag_on || !detect_q) begin
			flag_q <= 1'b0;
		end
	end

	// Power sequencing
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cp_run_q <= 1'b0;
			sp_run_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			cp_run_q <= cfg_q.charge_pump_on
				|| (ld_q.auto_charge_pump && load_st_q);
			sp_run_q <= (cfg_q.signal_path_on || (ld_q.auto_signal_path && load_st_q))
				&& cp_run_q && pin_s_q.settled;
			ext_q <= cp_run_q;
		end
	end

	// Sense domain: its own reset release, enable in and hit out
	always_ff @(posedge sense_clk) begin
		srst_m_q <= nrst;
		srst_s_q <= srst_m_q;
	end

	always_ff @(posedge sense_clk) begin
		if (!srst_s_q) begin
			en_m_q <= 1'b0;
			en_s_q <= 1'b0;
			raw_m_q <= 1'b0;
			raw_s_q <= 1'b0;
			sense_on_q <= 1'b0;
			hit_q <= 1'b0;
		end else begin
			en_m_q <= detect_q;
			en_s_q <= en_m_q;
			raw_m_q <= load_sense_i;
			raw_s_q <= raw_m_q;
			sense_on_q <= en_s_q;
			hit_q <= raw_s_q && en_s_q;
		end
	end

	// Open-drain pins only ever pull low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sda_o <= 1'b0;
			load_change_flag_n_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			load_change_flag_n_o <= 1'b0;
		end
	end

	assign sda_oe = oe_q;
	assign load_change_flag_n_oe = flag_q;
	assign charge_pump_run_o = cp_run_q;
	assign signal_path_run_o = sp_run_q;
	assign switch_ext_range_o = ext_q;
	assign switch_one_close_o = cfg_q.switch_one_close;
	assign switch_two_close_o = cfg_q.switch_two_close;
	assign sync_tip_clamp_on_o = cfg_q.sync_tip_clamp_on;
	assign video_filter_on_o = cfg_q.video_filter_on;
	assign load_sense_on_o = sense_on_q;

endmodule

// file: logic/ivp_regs.svh
// Register map, field masks and timing constants of the video power control slave
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

`define IVP_CFG_ADDR 8'h00
`define IVP_LD_ADDR 8'h01
`define IVP_CFG_RST 8'h00
`define IVP_LD_RST 8'h00
`define IVP_CFG_WMASK 8'hDB
`define IVP_LD_WMASK 8'h0B
`define IVP_DUMMY_DATA 8'hFF
`define IVP_ADDR_HI 5'h13
`define IVP_BYTE_BITS 4'h8
`define IVP_ACK_BITS 4'h9
`define IVP_SCL_MAX_KHZ 400
`define IVP_CLK_KHZ 100000
`define IVP_DEBOUNCE_MS 128

`endif

// file: logic/ivp_pkg.sv
// Types shared by the video power control slave
package ivp_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_PTR = 3'h2,
		ST_WDATA = 3'h3,
		ST_RDATA = 3'h4
	} ivp_state_t;

	typedef struct packed {
		logic switch_two_close;
		logic switch_one_close;
		logic rsv5;
		logic sync_tip_clamp_on;
		logic video_filter_on;
		logic rsv2;
		logic signal_path_on;
		logic charge_pump_on;
	} ivp_cfg_t;

	typedef struct packed {
		logic load;
		logic [2:0] rsv6_4;
		logic load_change_flag_on;
		logic rsv2;
		logic auto_signal_path;
		logic auto_charge_pump;
	} ivp_ld_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic strap;
		logic settled;
		logic load_hit;
	} ivp_pins_t;

endpackage

// file: tb/ivp_sva.sv
// Port-level checks of the video power control slave
`timescale 1ns/10ps

module ivp_sva (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_i,
	input wire logic cp_settled_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic load_change_flag_n_o,
	input wire logic load_change_flag_n_oe,
	input wire logic charge_pump_run_o,
	input wire logic signal_path_run_o,
	input wire logic switch_ext_range_o,
	input wire logic switch_one_close_o,
	input wire logic switch_two_close_o,
	input wire logic sync_tip_clamp_on_o,
	input wire logic video_filter_on_o,
	input wire logic load_sense_on_o
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	property p_ext; switch_ext_range_o == $past(charge_pump_run_o); endproperty
	property p_path; signal_path_run_o |-> $past(charge_pump_run_o); endproperty
	property p_pfall; $fell(charge_pump_run_o) |=> !signal_path_run_o && !switch_ext_range_o;
	endproperty
	property p_settle; $rose(signal_path_run_o) |-> cp_settled_i; endproperty
	// Bits may only move while the clock is low
	property p_hold; scl_i [*5] |-> $stable(sda_oe); endproperty
	property p_cfg; $changed({switch_two_close_o, switch_one_close_o, sync_tip_clamp_on_o,
		video_filter_on_o}) |-> !scl_i; endproperty
	property p_od; sda_o == 1'b0 && load_change_flag_n_o == 1'b0; endproperty
	property p_flag; $rose(load_change_flag_n_oe) |-> load_sense_on_o; endproperty
	a_ext: assert property (p_ext) else $error("range not following pump");
	a_path: assert property (p_path) else $error("path without pump");
	a_pfall: assert property (p_pfall) else $error("path left on");
	a_settle: assert property (p_settle) else $error("path before settle");
	a_hold: assert property (p_hold) else $error("data moved in clock high");
	a_cfg: assert property (p_cfg) else $error("config moved in clock high");
	a_od: assert property (p_od) else $error("open drain drives high");
	a_flag: assert property (p_flag) else $error("flag without sensing");
	c_ack: cover property ($rose(sda_oe));
	c_flag: cover property ($rose(load_change_flag_n_oe));
	c_path: cover property ($rose(signal_path_run_o));
endmodule

// file: tb/ivp_master.sv
// Behavioural serial bus master for the video power control slave
`timescale 1ns/10ps

module ivp_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_oe
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// 252 clk a bit keeps the serial clock below 400kHz
	task automatic q();
		repeat (63) @(negedge clk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_oe = !b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
		q();
	endtask
	// Also serves as repeated start
	task automatic start();
		sda_oe = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_oe = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic stop();
		sda_oe = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_oe = 1'b0;
		q();
	endtask
	task automatic tx(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack_n);
	endtask
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// file: tb/tb_i2c_video_power_control.sv
// Self-checking bench for the video power control slave
`timescale 1ns/10ps
`include "ivp_regs.svh"

module tb_i2c_video_power_control;
	logic clk, nrst, sense_clk, load_raw, settled, scl_w, m_oe, d_oe, f_oe;
	logic pump, path, ext, sw1, sw2, clamp, filt;
	logic [1:0] strap_sel;
	logic [3:0] st_cnt;
	logic [7:0] wb [3];
	logic [7:0] rb [3];
	integer seed, fail_count, checks;
	wire sda_w = !(m_oe | d_oe);
	wire strap = strap_sel[1] ? (strap_sel[0] ? sda_w : scl_w) : strap_sel[0];
	ivp_master u_mst(.clk, .sda(sda_w), .scl(scl_w), .sda_oe(m_oe));
	ivp_top #(.DEB_CYC(20)) u_dut(.clk, .nrst, .scl_i(scl_w), .sda_i(sda_w),
		.slave_address_strap(strap), .cp_settled_i(settled), .sense_clk,
		.load_sense_i(load_raw), .sda_o(), .sda_oe(d_oe), .load_change_flag_n_o(),
		.load_change_flag_n_oe(f_oe), .charge_pump_run_o(pump), .signal_path_run_o(path),
		.switch_ext_range_o(ext), .switch_one_close_o(sw1), .switch_two_close_o(sw2),
		.sync_tip_clamp_on_o(clamp), .video_filter_on_o(filt), .load_sense_on_o());
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		sense_clk = 1'b0;
		#7;
		forever #16 sense_clk = ~sense_clk;
	end
	// Pump settles ten cycles after it starts
	always @(negedge clk) begin
		st_cnt <= !pump ? 4'h0 : (st_cnt == 4'hA ? st_cnt : st_cnt + 4'h1);
		settled <= st_cnt == 4'hA;
	end
	function automatic logic [7:0] ld_exp(input logic [7:0] v, input logic l);
		return (v & `IVP_LD_WMASK) | ((l && v[1:0] != 2'h0) ? 8'h80 : 8'h00);
	endfunction
	function automatic logic [2:0] pwr_exp(input logic [7:0] c, input logic [7:0] v, input logic l);
		logic p;
		p = c[0] | (v[0] & l);
		return {p, (c[1] | (v[1] & l)) & p, p};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic txa(input logic [7:0] v, input logic e);
		logic k;
		u_mst.tx(v, k);
		chk("ack", {7'h00, e}, {7'h00, k});
	endtask
	task automatic wr(input logic [7:0] p, input int n);
		u_mst.start();
		txa(8'h98, 1'b0);
		txa(p, 1'b0);
		for (int i = 0; i < n; i++) txa(wb[i], 1'b0);
		u_mst.stop();
	endtask
	task automatic rd(input int p, input int n);
		if (p >= 0) begin
			u_mst.start();
			txa(8'h98, 1'b0);
			txa(p[7:0], 1'b0);
		end
		u_mst.start();
		txa(8'h99, 1'b0);
		for (int i = 0; i < n; i++) u_mst.rx(i == n - 1, rb[i]);
		u_mst.stop();
	endtask
	// p below zero reads from the retained pointer, which saves a pointer frame
	task automatic chk_all(input int p, input logic [7:0] c, input logic [7:0] v,
		input logic l);
		rd(p, 3);
		chk("cfg", c & `IVP_CFG_WMASK, rb[0]);
		chk("load reg", ld_exp(v, l), rb[1]);
		chk("dummy", `IVP_DUMMY_DATA, rb[2]);
		chk("pins", {1'b0, pwr_exp(c, v, l), c[7], c[6], c[4], c[3]},
			{1'b0, pump, path, ext, sw2, sw1, clamp, filt});
		$display("test cfg %h load reg %h done", c, v);
	endtask
	initial begin
		seed = 43514;
		fail_count = 0;
		checks = 0;
		nrst = 1'b0;
		load_raw = 1'b0;
		strap_sel = 2'h0;
		st_cnt = 4'h0;
		settled = 1'b0;
		// Held long enough for the sense domain too
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (8) @(negedge clk);
		chk_all(-1, 8'h00, 8'h00, 1'b0);
		for (int s = 0; s < 4; s++) begin
			strap_sel = s[1:0];
			u_mst.start();
			txa(8'h98 | {5'h00, s[1:0] + 2'h1, 1'b0}, 1'b1);
			u_mst.start();
			txa(8'h98 | {5'h00, s[1:0], 1'b0}, 1'b0);
			u_mst.stop();
		end
		strap_sel = 2'h0;
		$display("test strap done");
		for (int i = 0; i < 3; i++) wb[i] = 8'($random(seed));
		wr(8'h00, 3);
		chk_all(0, wb[0], wb[1], 1'b0);
		wb[0] = 8'h00;
		wb[1] = 8'h0B;
		wr(8'h00, 2);
		rd(-1, 1);
		chk("retained", `IVP_DUMMY_DATA, rb[0]);
		load_raw = 1'b1;
		repeat (8) @(negedge clk);
		load_raw = 1'b0;
		repeat (60) @(negedge clk);
		chk("glitch", 8'h00, {7'h00, f_oe});
		load_raw = 1'b1;
		repeat (15) @(negedge clk);
		chk("early", 8'h00, {7'h00, f_oe});
		for (int k = 0; k < 200 && f_oe !== 1'b1; k++) @(negedge clk);
		chk("flag", 8'h01, {7'h00, f_oe});
		if (f_oe !== 1'b1) final_report();
		chk_all(0, 8'h00, 8'h0B, 1'b1);
		chk("release", 8'h00, {7'h00, f_oe});
		wb[0] = 8'h01;
		wb[1] = 8'h02;
		wr(8'h00, 2);
		load_raw = 1'b0;
		repeat (100) @(negedge clk);
		chk("no flag", 8'h00, {7'h00, f_oe});
		chk_all(0, 8'h01, 8'h02, 1'b0);
		final_report();
	end
	initial begin
		repeat (120000) @(posedge clk);
		fail_count++;
		final_report();
	end
endmodule

bind ivp_top ivp_sva u_sva(.clk, .nrst, .scl_i, .cp_settled_i, .sda_o, .sda_oe,
	.load_change_flag_n_o, .load_change_flag_n_oe, .charge_pump_run_o, .signal_path_run_o,
	.switch_ext_range_o, .switch_one_close_o, .switch_two_close_o, .sync_tip_clamp_on_o,
	.video_filter_on_o, .load_sense_on_o);
